// File: hw/tpc_top.sv
// Low-power pulse/time counter with Avalon-MM register slave.
// Assumes clock source enables and pulse inputs synchronous to ref_clk_in.
//
// Chosen here: the register offsets and register access over Avalon-MM.
`include "tpc_regs.svh"
`timescale 1ns/1ns
module tpc_top (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [`TPC_ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [3:0] clk_src_en_in,
  input wire logic [3:0] pulse_in,
  output logic irq_out,
  output logic dma_req_out,
  output logic trigger_out
);
  tpc_pkg::tpc_ctrl_s ctrl_q;
  tpc_pkg::tpc_psc_s psc_q;
  logic [`TPC_CNT_W-1:0] cmp_q;
  logic [`TPC_CNT_W-1:0] cnt_q;
  logic flag_q;
  logic ack_q;
  logic pulse_lvl_q;
  logic pulse_prev_q;
  logic src_lvl;
  logic src_edge;
  logic pre_tick;
  logic count_en;
  logic match;
  logic wr_ctrl;
  logic wr_cmp;
  logic wr_psc;
  logic use_filter;
  logic is_pulse;

  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  // Bus handshake: one wait cycle, then accept
  logic req;
  assign req = (avs_read_in || avs_write_in) && !ack_q;
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      ack_q <= 1'b0;
      avs_waitrequest_out <= 1'b1;
    end else begin
      ack_q <= req;
      avs_waitrequest_out <= !req;
    end
  end

  assign wr_ctrl = avs_write_in && ack_q && avs_address_in == `TPC_OFF_CTRL;
  assign wr_psc = avs_write_in && ack_q && avs_address_in == `TPC_OFF_PSC;
  assign wr_cmp = avs_write_in && ack_q && avs_address_in == `TPC_OFF_CMP;

  logic [31:0] ctrl_word;
  logic [31:0] ctrl_new;
  logic [31:0] psc_new;
  logic [31:0] cmp_new;
  assign ctrl_word = {23'h0, flag_q, ctrl_q};
  assign ctrl_new = be_merge(ctrl_word, avs_writedata_in, avs_byteenable_in);
  assign psc_new = be_merge({25'h0, psc_q}, avs_writedata_in, avs_byteenable_in);
  assign cmp_new = be_merge({16'h0, cmp_q}, avs_writedata_in, avs_byteenable_in);

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      ctrl_q <= tpc_pkg::tpc_ctrl_s'(`TPC_CTRL_RST);
    end else if (wr_ctrl) begin
      ctrl_q <= tpc_pkg::tpc_ctrl_s'(ctrl_new[7:0]);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      psc_q <= tpc_pkg::tpc_psc_s'(`TPC_PSC_RST);
    end else if (wr_psc) begin
      psc_q <= tpc_pkg::tpc_psc_s'(psc_new[6:0]);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      cmp_q <= `TPC_CMP_RST;
    end else if (wr_cmp) begin
      cmp_q <= cmp_new[15:0];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && req) begin
      unique case (avs_address_in)
        `TPC_OFF_CTRL: avs_readdata_out <= ctrl_word;
        `TPC_OFF_PSC: avs_readdata_out <= {25'h0, psc_q};
        `TPC_OFF_CMP: avs_readdata_out <= {16'h0, cmp_q};
        `TPC_OFF_CNT: avs_readdata_out <= {16'h0, cnt_q};
        default: avs_readdata_out <= 32'h0000_0000;
      endcase
    end
  end

  // Count source selection
  assign is_pulse = ctrl_q.count_mode_select == tpc_pkg::TPC_MODE_PULSE;
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || !ctrl_q.enable) begin
      pulse_lvl_q <= 1'b0;
      pulse_prev_q <= 1'b0;
    end else begin
      pulse_lvl_q <= pulse_in[ctrl_q.pulse_input_select] ^ ctrl_q.pulse_input_polarity;
      pulse_prev_q <= pulse_lvl_q;
    end
  end
  assign src_edge = pulse_lvl_q && !pulse_prev_q;
  // Pulse level for filter, clock source enable for prescale
  assign src_lvl = is_pulse ? pulse_lvl_q : clk_src_en_in[psc_q.count_clock_select];
  assign use_filter = is_pulse;

  tpc_prescale u_prescale (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .run_in(ctrl_q.enable && !psc_q.prescale_bypass),
    .filter_in(use_filter),
    .value_in(psc_q.prescale_value),
    .src_in(src_lvl),
    .tick_out(pre_tick)
  );

  // Bypass picks raw source, else prescaler tick
  always_comb begin
    if (psc_q.prescale_bypass) begin
      count_en = is_pulse ? src_edge : clk_src_en_in[psc_q.count_clock_select];
    end else begin
      count_en = pre_tick;
    end
  end

  assign match = count_en && cnt_q == cmp_q;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || !ctrl_q.enable) begin
      cnt_q <= '0;
    end else if (count_en) begin
      if (match && !ctrl_q.free_run_select) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  // Sticky flag, write one to clear, set wins
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      flag_q <= 1'b0;
    end else if (match) begin
      flag_q <= 1'b1;
    end else if (wr_ctrl && avs_byteenable_in[1] && avs_writedata_in[`TPC_CTRL_FLAG]) begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      irq_out <= 1'b0;
      dma_req_out <= 1'b0;
      trigger_out <= 1'b0;
    end else begin
      irq_out <= ctrl_q.irq_en && (flag_q || match) && !(wr_ctrl && avs_byteenable_in[1]
        && avs_writedata_in[`TPC_CTRL_FLAG] && !match);
      dma_req_out <= ctrl_q.dma_en && match;
      trigger_out <= match;
    end
  end
endmodule : tpc_top

// File: hw/tpc_regs.svh
// Register map, field positions, reset values and counts for the pulse/time counter.
// Assumes a 32-bit Avalon-MM slave with byte addresses, word aligned.
`ifndef TPC_REGS_SVH
`define TPC_REGS_SVH
`define TPC_ADDR_W 4
`define TPC_OFF_CTRL 4'h0
`define TPC_OFF_PSC 4'h4
`define TPC_OFF_CMP 4'h8
`define TPC_OFF_CNT 4'hC
`define TPC_CTRL_EN 0
`define TPC_CTRL_MODE 1
`define TPC_CTRL_FREE 2
`define TPC_CTRL_POL 3
`define TPC_CTRL_SEL_LO 4
`define TPC_CTRL_SEL_HI 5
`define TPC_CTRL_IE 6
`define TPC_CTRL_DMAE 7
`define TPC_CTRL_FLAG 8
`define TPC_PSC_VAL_LO 0
`define TPC_PSC_VAL_HI 3
`define TPC_PSC_BYP 4
`define TPC_PSC_CLK_LO 5
`define TPC_PSC_CLK_HI 6
`define TPC_CTRL_RST 32'h0000_0000
`define TPC_PSC_RST 32'h0000_0030
`define TPC_CMP_RST 16'h0000
`define TPC_CNT_W 16
`define TPC_DIV_W 17
`endif

// File: hw/tpc_pkg.sv
// Types shared by the pulse/time counter files.
// Assumes the register header is compiled alongside.
package tpc_pkg;
  typedef enum logic {
    TPC_MODE_TIME,
    TPC_MODE_PULSE
  } tpc_mode_e;
  typedef struct packed {
    logic dma_en;
    logic irq_en;
    logic [1:0] pulse_input_select;
    logic pulse_input_polarity;
    logic free_run_select;
    tpc_mode_e count_mode_select;
    logic enable;
  } tpc_ctrl_s;
  typedef struct packed {
    logic [1:0] count_clock_select;
    logic prescale_bypass;
    logic [3:0] prescale_value;
  } tpc_psc_s;
endpackage : tpc_pkg

// File: hw/tpc_prescale.sv
// Prescaler and glitch filter of the pulse/time counter.
// Assumes all inputs are synchronous to ref_clk_in; src_in is a level or enable.
`include "tpc_regs.svh"
`timescale 1ns/1ns
module tpc_prescale (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  input wire logic filter_in,
  input wire logic [3:0] value_in,
  input wire logic src_in,
  output logic tick_out
);
  logic [`TPC_DIV_W-1:0] cnt_q;
  logic [`TPC_DIV_W-1:0] limit;
  logic filt_q;

  // Terminal count: 2^(n+1) prescale, 2^n filter
  always_comb begin
    limit = '0;
    if (filter_in) begin
      limit[value_in] = 1'b1;
    end else begin
      limit[value_in + 4'h1] = 1'b1;
      if (value_in == 4'hF) begin
        limit = {1'b1, 16'h0000};
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || !run_in) begin
      cnt_q <= '0;
      filt_q <= 1'b0;
      tick_out <= 1'b0;
    end else if (filter_in) begin
      tick_out <= 1'b0;
      if (src_in == filt_q) begin
        cnt_q <= '0;
      end else if (cnt_q + 17'h1 >= limit) begin
        cnt_q <= '0;
        filt_q <= src_in;
        tick_out <= src_in;
      end else begin
        cnt_q <= cnt_q + 17'h1;
      end
    end else begin
      tick_out <= 1'b0;
      if (src_in) begin
        if (cnt_q + 17'h1 >= limit) begin
          cnt_q <= '0;
          tick_out <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 17'h1;
        end
      end
    end
  end
endmodule : tpc_prescale

// File: tb/tpc_src_model.sv
// Far side: count clock source enables and pulse pins.
// Assumes the bench sets the pin levels.
`timescale 1ns/1ns
module tpc_src_model (
  input wire logic ref_clk_in,
  input wire logic [3:0] level_in,
  output logic [3:0] clk_src_en_out,
  output logic [3:0] pulse_out
);
  logic [2:0] ph_q = 3'h0;
  always @(posedge ref_clk_in) begin
    ph_q <= ph_q + 3'h1;
    pulse_out <= level_in;
  end
  // Source k fires once every 2^k cycles
  assign clk_src_en_out = {&ph_q, &ph_q[1:0], ph_q[0], 1'b1};
endmodule : tpc_src_model

// File: tb/tpc_chk.sv
// Checker of bus, interrupt and trigger ports.
// Assumes it is bound to tpc_top.
`timescale 1ns/1ns
module tpc_chk (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic irq_out,
  input wire logic dma_req_out,
  input wire logic trigger_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic rq, wr, wq;
  assign rq = avs_read_in || avs_write_in;
  assign wr = avs_write_in;
  assign wq = avs_waitrequest_out;
  a_wait_take: assert property (rq && wq |=> !wq) else $error("no accept");
  a_wait_one: assert property (!wq |=> wq) else $error("long accept");
  a_wait_idle: assert property (!rq && wq |=> wq) else $error("idle accept");
  a_rdata_cause: assert property ($changed(avs_readdata_out) |-> avs_read_in && !wq) else $error("stray data");
  a_reset_quiet: assert property ($rose(rst_n_in) |-> wq && !irq_out && !trigger_out) else $error("busy at start");
  a_dma_trig: assert property (dma_req_out |-> trigger_out) else $error("dma alone");
  a_irq_rise: assert property ($rose(irq_out) |-> trigger_out || $past(wr) || $past(wr, 2))
    else $error("irq alone");
  a_irq_hold: assert property (irq_out && !wr && !$past(wr) && !$past(wr, 2) |=> irq_out)
    else $error("irq dropped");
  c_trig: cover property (trigger_out && dma_req_out);
  c_irq: cover property (irq_out);
  c_read: cover property (avs_read_in && !wq);
endmodule : tpc_chk
bind tpc_top tpc_chk chk_u (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
  .irq_out(irq_out), .dma_req_out(dma_req_out), .trigger_out(trigger_out));

// File: tb/timer_pulse_counter_bench.sv
// Bench: time and pulse counting scenarios.
// Assumes design, source model and checker compiled.
`include "tpc_regs.svh"
`timescale 1ns/1ns
module timer_pulse_counter_bench;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] lvl = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat, q;
  logic [3:0] en, pin;
  logic wq, irq, dma, trig;
  int bad_count = 0;
  int samples_checked = 0;
  int p;
  always #2 ref_clk_in = ~ref_clk_in;
  tpc_top dut_u (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hF), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wq), .clk_src_en_in(en), .pulse_in(pin), .irq_out(irq), .dma_req_out(dma),
    .trigger_out(trig));
  tpc_src_model src_u (.ref_clk_in(ref_clk_in), .level_in(lvl), .clk_src_en_out(en), .pulse_out(pin));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    wr <= w;
    rd <= !w;
    adr <= a;
    wd <= d;
    do @(posedge ref_clk_in); while (wq !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic period();
    do @(posedge ref_clk_in); while (trig !== 1'b1);
    p = 0;
    do begin
      @(posedge ref_clk_in);
      p++;
    end while (trig !== 1'b1);
  endtask : period
  task automatic t_time(input logic [31:0] psc, input int exp);
    bus(1, `TPC_OFF_CTRL, 32'h0);
    bus(1, `TPC_OFF_PSC, psc);
    bus(1, `TPC_OFF_CMP, 32'h5);
    bus(1, `TPC_OFF_CTRL, 32'hC1);
    period();
    chk(p, exp);
    chk(dma, 1'b1);
    chk(irq, 1'b1);
    $display("time test done");
  endtask : t_time
  task automatic t_flag();
    bus(0, `TPC_OFF_CTRL, 0);
    chk(q, 32'h1C1);
    bus(1, `TPC_OFF_CTRL, 32'h100);
    bus(0, `TPC_OFF_CTRL, 0);
    chk(q, 32'h0);
    chk(irq, 1'b0);
    bus(0, `TPC_OFF_CNT, 0);
    chk(q, 32'h0);
    $display("flag test done");
  endtask : t_flag
  task automatic t_free();
    bus(1, `TPC_OFF_PSC, 32'h10);
    bus(1, `TPC_OFF_CMP, 32'h2);
    bus(1, `TPC_OFF_CTRL, 32'h05);
    period();
    chk(p, 65536);
    chk(irq, 1'b0);
    chk(dma, 1'b0);
    bus(1, `TPC_OFF_CTRL, 32'h100);
    $display("free test done");
  endtask : t_free
  task automatic pulse(input int n, input logic act, input int w);
    @(posedge ref_clk_in);
    lvl[n] <= act;
    repeat (w) @(posedge ref_clk_in);
    lvl[n] <= !act;
    repeat (w) @(posedge ref_clk_in);
  endtask : pulse
  task automatic t_pulse(input int s, input logic pol, input logic [31:0] psc, input int w, input int exp);
    lvl <= {4{pol}};
    bus(1, `TPC_OFF_CMP, 32'hFF);
    bus(1, `TPC_OFF_PSC, psc);
    bus(1, `TPC_OFF_CTRL, 32'h03 | (pol << 3) | (s << 4));
    repeat (3) pulse(s, !pol, w);
    pulse((s + 1) % 4, !pol, w);
    bus(0, `TPC_OFF_CNT, 0);
    chk(q, exp);
    bus(1, `TPC_OFF_CTRL, 32'h0);
    $display("pulse test done");
  endtask : t_pulse
  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results
  initial begin
    repeat (4) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    bus(0, `TPC_OFF_PSC, 0);
    chk(q, `TPC_PSC_RST);
    for (int k = 0; k < 4; k++) t_time(32'h10 | (k << 5), 6 << k);
    t_time(32'h00, 12);
    t_time(32'h21, 48);
    t_flag();
    t_free();
    for (int s = 0; s < 8; s++) t_pulse(s >> 1, s[0], 32'h10, 4, 3);
    t_pulse(0, 1'b0, 32'h02, 2, 0);
    t_pulse(1, 1'b1, 32'h02, 8, 3);
    results();
  end
  initial begin
    #400000;
    bad_count++;
    results();
  end
endmodule : timer_pulse_counter_bench
